/* File: core/hbc_pkg.sv */
// hbc_pkg: constants, enums and helpers of the host bus config block.
// assumes: one design file imports the whole package.
package hbc_pkg;

  localparam int DATA_W = 16;

  // indirect port selects
  localparam logic [1:0] PORT_INDEX = 2'h0;
  localparam logic [1:0] PORT_DATA  = 2'h1;
  localparam logic [1:0] PORT_CTRL  = 2'h2;

  // strap four..six patterns
  localparam logic [2:0] TYPE_SERIAL      = 3'h3;
  localparam logic [2:0] TYPE_WR_A        = 3'h1;
  localparam logic [2:0] TYPE_WR_B        = 3'h5;
  localparam logic [2:0] TYPE_GPIO_DIRECT = 3'h6;
  // straps two and three that hand pins to the camera
  localparam logic [1:0] CAM_WIDTH_DIR    = 2'h2;

  // index and control fields
  localparam int IDX_BYTE_BIT = 15;
  localparam int IDX_LANE_BIT = 0;
  localparam int CTRL_MEM_BIT = 0;
  localparam logic [15:0] INDEX_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST  = 16'h0000;

  // software register port
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_CFG    = 2'h1;
  localparam logic [1:0] REG_INDEX  = 2'h2;
  localparam int CFG_EN_BIT = 0;
  localparam logic [15:0] CFG_RST = 16'h0001;

  // lane enables, bit 0 is the low byte
  localparam logic [1:0] BE_LOW  = 2'h1;
  localparam logic [1:0] BE_HIGH = 2'h2;
  localparam logic [1:0] BE_BOTH = 2'h3;

  typedef enum logic [1:0] {FAM_GENERIC, FAM_A, FAM_B} hbc_fam_e;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_HOLD} hbc_state_e;

  // families whose lane pins are write strobes
  function automatic logic hbc_lane_wr(input logic [2:0] t);
    return (t == TYPE_WR_A) || (t == TYPE_WR_B);
  endfunction

  // single lane from an address or index bit
  function automatic logic [1:0] hbc_lane_be(input logic hi);
    return hi ? BE_HIGH : BE_LOW;
  endfunction

endpackage

/* File: core/hbc_lane_map.sv */
// hbc_lane_map: strap decode, byte-lane mapping and access sequencing
// of the parallel host port.
// assumes: all host pins are asynchronous to clock; the core side answers
// a held request with a one-cycle ack on the same clock.
// Behaviour
// - first strap high picks family A (second low) or family B (high)
// - family A is 16-bit only; lowest address pin picks direct/indirect
// - family B is 16-bit only; high lane pin low indirect, high direct
// - first strap low: error, burst-progress, burst pins become straps 3-5
// - first strap low: second strap low 8-bit, high 16-bit bus
// - first strap low: third strap high direct, low indirect
// - indirect: upper address unused, address pin 3 is strap six
// - direct 8-bit: high lane pin freed as strap six
// - direct 16-bit: lowest address pin freed as strap six
// - straps 4-6 of 011b give serial; address pin 4 picks 4 or 2 wire
// - serial choice decodes alike for all second/third strap values
// - straps 10b, 011b, seventh 0b: idle bus pins feed camera one
// - non-serial indirect modes and one direct 16-bit family free pins for gpio
// - 16-bit lane-enable families drive both bytes on reads
// - direct 16-bit per-lane strobe families: strobes are byte writes, reads full word
// - 16-bit indirect: index bit 15 turns data accesses into bytes
// - byte access: index bit 0 low uses low lane, high uses high lane
// - direct modes: memory/register select pin steers each access
// - multi-byte values are little-endian only
// - indirect exposes index, data, control at ports 00b, 01b, 10b
`timescale 1ns/1ps
module hbc_lane_map
  import hbc_pkg::*;
#(
  parameter int AW = 21
)(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              clkEn,
  input  wire logic              strapFamilyGroup,
  input  wire logic              strapWidthOrFamily,
  input  wire logic              hostCsN,
  input  wire logic              hostRdN,
  input  wire logic              hostRdWrN,
  input  wire logic              lowLaneEnableN,
  input  wire logic              highLaneEnableN,
  input  wire logic              memRegSel,
  input  wire logic              busErrorAckN,
  input  wire logic              burstInProgressN,
  input  wire logic              burstReqN,
  input  wire logic [AW-1:0]     hostAddr,
  input  wire logic [DATA_W-1:0] hostDataIn,
  output logic [DATA_W-1:0]      hostDataOut,
  output logic                   hostDataOeLow,
  output logic                   hostDataOeHigh,
  output logic                   hostWaitN,
  output logic                   coreReq,
  output logic                   coreWrite,
  output logic                   coreMem,
  output logic [AW-1:0]          coreAddr,
  output logic [DATA_W-1:0]      coreWdata,
  output logic [1:0]             coreByteEn,
  input  wire logic [DATA_W-1:0] coreRdata,
  input  wire logic              coreAck,
  output logic [1:0]             busFamily,
  output logic                   bus16,
  output logic                   busDirect,
  output logic [2:0]             busType,
  output logic                   serialSel,
  output logic                   serialTwoWire,
  output logic                   cameraStream,
  output logic                   gpioHandover,
  input  wire logic [1:0]        regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [DATA_W-1:0]      regRdata
);

  // one synchroniser stage of every host pin
  typedef struct packed {
    logic              fg;
    logic              wf;
    logic              csN;
    logic              rdN;
    logic              rwN;
    logic              loN;
    logic              hiN;
    logic              mr;
    logic              ea;
    logic              bp;
    logic              bu;
    logic [AW-1:0]     addr;
    logic [DATA_W-1:0] d;
  } hbc_pin_s;

  // strap snapshot taken while in reset
  typedef struct packed {
    logic fg;
    logic wf;
    logic s3;
    logic s4;
    logic s5;
    logic a0;
    logic a3;
    logic a4;
    logic hi;
  } hbc_snap_s;

  typedef struct packed {
    hbc_pin_s          sA;
    hbc_pin_s          sB;
    hbc_snap_s         snap;
    hbc_state_e        state;
    logic [15:0]       index;
    logic [15:0]       ctrl;
    logic [15:0]       cfg;
    logic              idxHi;
    logic [DATA_W-1:0] dataOut;
    logic              dataOe;
    logic              waitAct;
    logic              coreReq;
    logic              coreWr;
    logic              coreMem;
    logic [AW-1:0]     coreAddr;
    logic [DATA_W-1:0] coreWd;
    logic [1:0]        coreBe;
    logic [DATA_W-1:0] regRd;
  } hbc_st_s;

  hbc_st_s   st_r;
  hbc_st_s   st_nxt;
  hbc_pin_s  pinNow;
  hbc_pin_s  p;
  hbc_fam_e  dFam;
  logic      dWide;
  logic      dDirect;
  logic      dSix;
  logic [2:0] dType;
  logic      dSerial;
  logic      dTwoWire;
  logic      dCamera;
  logic      dGpio;
  logic      laneWr;
  logic      rdAct;
  logic      wrAct;
  logic      start;
  logic      hostEn;
  logic [1:0] port;

  assign pinNow = {strapFamilyGroup, strapWidthOrFamily, hostCsN,
                   hostRdN, hostRdWrN, lowLaneEnableN, highLaneEnableN,
                   memRegSel, busErrorAckN, burstInProgressN, burstReqN,
                   hostAddr, hostDataIn};
  assign p = st_r.sB;

  // strap decode; the snapshot never moves outside reset
  always_comb begin
    dFam     = FAM_GENERIC;
    dWide    = 1'b1;
    dDirect  = 1'b1;
    dSix     = 1'b0;
    dType    = 3'h0;
    dSerial  = 1'b0;
    dTwoWire = 1'b0;
    dCamera  = 1'b0;
    if (st_r.snap.fg) begin
      if (st_r.snap.wf) begin
        dFam    = FAM_B;
        dDirect = st_r.snap.hi;
      end else begin
        dFam    = FAM_A;
        dDirect = st_r.snap.a0;
      end
    end else begin
      dWide   = st_r.snap.wf;
      dDirect = st_r.snap.s3;
      if (!dDirect) begin
        dSix = st_r.snap.a3;
      end else if (!dWide) begin
        dSix = st_r.snap.hi;
      end else begin
        dSix = st_r.snap.a0;
      end
      dType   = {st_r.snap.s4, st_r.snap.s5, dSix};
      // wide and direct bits take no part in the serial choice on purpose; camera uses them
      dSerial  = (dType == TYPE_SERIAL);
      dTwoWire = dSerial && st_r.snap.a4;
      dCamera  = dSerial && !st_r.snap.a4 &&
                 ({st_r.snap.wf, st_r.snap.s3} == CAM_WIDTH_DIR);
    end
    dGpio = !dSerial && (!dDirect ||
            (dWide && dType == TYPE_GPIO_DIRECT));
  end

  // strobe decode of the synchronised pins
  always_comb begin
    laneWr = !st_r.snap.fg && hbc_lane_wr(dType);
    hostEn = st_r.cfg[CFG_EN_BIT];
    if (laneWr) begin
      // both lane pins on one host strobe on a 16-bit bus; only the low lane pin on an 8-bit bus
      wrAct = !p.loN || (dWide && !p.hiN);
      rdAct = !p.rdN;
    end else begin
      wrAct = !p.rwN;
      rdAct = !p.rdN && p.rwN;
    end
    start = !p.csN && (rdAct || wrAct);
    port  = dWide ? p.addr[2:1] : p.addr[1:0];
  end

  // next state of the whole block
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sA    = pinNow;
    st_nxt.sB    = st_r.sA;
    st_nxt.regRd = 16'h0000;
    if (!nrst) begin
      // straps are caught from the second sync stage while held
      st_nxt.snap = '{fg: p.fg, wf: p.wf, s3: p.ea, s4: p.bp,
                      s5: p.bu, a0: p.addr[0], a3: p.addr[3],
                      a4: p.addr[4], hi: p.hiN};
      st_nxt.state    = ST_IDLE;
      st_nxt.index    = INDEX_RST;
      st_nxt.ctrl     = CTRL_RST;
      st_nxt.cfg      = CFG_RST;
      st_nxt.idxHi    = 1'b0;
      st_nxt.dataOut  = 16'h0000;
      st_nxt.dataOe   = 1'b0;
      st_nxt.waitAct  = 1'b0;
      st_nxt.coreReq  = 1'b0;
      st_nxt.coreWr   = 1'b0;
      st_nxt.coreMem  = 1'b0;
      st_nxt.coreAddr = '0;
      st_nxt.coreWd   = 16'h0000;
      st_nxt.coreBe   = 2'h0;
    end else begin
      // software side
      if (regWr && regAddr == REG_CFG) begin
        st_nxt.cfg = regWdata;
      end
      if (regRd) begin
        unique case (regAddr)
          REG_STATUS: st_nxt.regRd = {4'h0, st_r.state != ST_IDLE,
                        dGpio, dCamera, dTwoWire, dSerial, dType,
                        dDirect, dWide, dFam};
          REG_CFG:    st_nxt.regRd = st_r.cfg;
          REG_INDEX:  st_nxt.regRd = st_r.index;
          default:    st_nxt.regRd = 16'h0000;
        endcase
      end
      unique case (st_r.state)
        ST_IDLE: begin
          // a disabled or serial port leaves host cycles unanswered
          if (start && hostEn && !dSerial) begin
            st_nxt.coreWr = wrAct;
            st_nxt.coreWd = dWide ? p.d : {p.d[7:0], p.d[7:0]};
            st_nxt.state  = ST_HOLD;
            if (dDirect) begin
              st_nxt.coreAddr = p.addr;
              st_nxt.coreMem  = p.mr;
              if (!dWide) begin
                // even byte address is the low lane
                st_nxt.coreBe = hbc_lane_be(p.addr[0]);
              end else if (laneWr && !wrAct) begin
                st_nxt.coreBe = BE_BOTH;
              end else begin
                st_nxt.coreBe = ~{p.hiN, p.loN};
              end
              st_nxt.coreReq = 1'b1;
              st_nxt.waitAct = 1'b1;
              st_nxt.state   = ST_REQ;
            end else begin
              unique case (port)
                PORT_DATA: begin
                  st_nxt.coreAddr = AW'(st_r.index[14:0]);
                  st_nxt.coreMem  = st_r.ctrl[CTRL_MEM_BIT];
                  if (!dWide || st_r.index[IDX_BYTE_BIT]) begin
                    st_nxt.coreBe =
                      hbc_lane_be(st_r.index[IDX_LANE_BIT]);
                  end else begin
                    st_nxt.coreBe = BE_BOTH;
                  end
                  st_nxt.coreReq = 1'b1;
                  st_nxt.waitAct = 1'b1;
                  st_nxt.state   = ST_REQ;
                end
                PORT_INDEX: begin
                  // narrow bus walks the index low byte first
                  if (wrAct && dWide) begin
                    st_nxt.index = p.d;
                  end else if (wrAct && st_r.idxHi) begin
                    st_nxt.index[15:8] = p.d[7:0];
                  end else if (wrAct) begin
                    st_nxt.index[7:0] = p.d[7:0];
                  end
                  if (!dWide) begin
                    st_nxt.idxHi = !st_r.idxHi;
                  end
                  if (dWide) begin
                    st_nxt.dataOut = st_r.index;
                  end else if (st_r.idxHi) begin
                    st_nxt.dataOut = {8'h00, st_r.index[15:8]};
                  end else begin
                    st_nxt.dataOut = {8'h00, st_r.index[7:0]};
                  end
                  st_nxt.dataOe = !wrAct;
                end
                PORT_CTRL: begin
                  if (wrAct && dWide) begin
                    st_nxt.ctrl = p.d;
                  end else if (wrAct) begin
                    st_nxt.ctrl[7:0] = p.d[7:0];
                  end
                  st_nxt.dataOut = dWide ? st_r.ctrl :
                                   {8'h00, st_r.ctrl[7:0]};
                  st_nxt.dataOe  = !wrAct;
                end
                default: begin
                  // unmapped port: writes dropped, reads zero
                  st_nxt.dataOut = 16'h0000;
                  st_nxt.dataOe  = !wrAct;
                end
              endcase
            end
          end
        end
        ST_REQ: begin
          if (coreAck) begin
            st_nxt.coreReq = 1'b0;
            st_nxt.waitAct = 1'b0;
            st_nxt.state   = ST_HOLD;
            if (!st_r.coreWr) begin
              if (dWide) begin
                st_nxt.dataOut = coreRdata;
              end else if (st_r.coreBe[1]) begin
                st_nxt.dataOut = {8'h00, coreRdata[15:8]};
              end else begin
                st_nxt.dataOut = {8'h00, coreRdata[7:0]};
              end
              st_nxt.dataOe = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          // data stays driven until the host lets go of its strobe
          if (!start) begin
            st_nxt.dataOe = 1'b0;
            st_nxt.state  = ST_IDLE;
          end
        end
      endcase
    end
  end

  // single register stage; clkEn low freezes everything, reset included
  always_ff @(posedge clock) begin
    if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign hostDataOut    = st_r.dataOut;
  assign hostDataOeLow  = st_r.dataOe;
  assign hostDataOeHigh = st_r.dataOe && dWide;
  assign hostWaitN      = !st_r.waitAct;
  assign coreReq        = st_r.coreReq;
  assign coreWrite      = st_r.coreWr;
  assign coreMem        = st_r.coreMem;
  assign coreAddr       = st_r.coreAddr;
  assign coreWdata      = st_r.coreWd;
  assign coreByteEn     = st_r.coreBe;
  assign busFamily      = dFam;
  assign bus16          = dWide;
  assign busDirect      = dDirect;
  assign busType        = dType;
  assign serialSel      = dSerial;
  assign serialTwoWire  = dTwoWire;
  assign cameraStream   = dCamera;
  assign gpioHandover   = dGpio;
  assign regRdata       = st_r.regRd;

  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  strap_hold_a: assert property (
    $past(nrst) |-> $stable(st_r.snap))
    else $error("strap snapshot moved outside reset");

  family_pick_a: assert property (
    st_r.snap.fg |-> bus16 && busFamily ==
      (st_r.snap.wf ? FAM_B : FAM_A))
    else $error("wide family choice wrong");

  serial_dec_a: assert property (
    !st_r.snap.fg && busType == TYPE_SERIAL |->
      serialSel && serialTwoWire == st_r.snap.a4)
    else $error("serial link decode wrong");

  camera_map_a: assert property (
    cameraStream |-> serialSel && !serialTwoWire &&
      bus16 && !busDirect)
    else $error("camera pins given outside their mode");

  wait_during_a: assert property (
    coreReq |-> !hostWaitN)
    else $error("wait free while request pending");

  wait_release_a: assert property (
    coreReq && coreAck && clkEn |=> hostWaitN && !coreReq)
    else $error("wait not freed after ack");

  read_data_a: assert property (
    coreReq && coreAck && clkEn && !coreWrite && bus16 |=>
      hostDataOut == $past(coreRdata) && hostDataOeHigh)
    else $error("wide read not driven on both lanes");

  byte_lane_a: assert property (
    $rose(coreReq) && !busDirect && bus16 &&
      st_r.index[IDX_BYTE_BIT] |->
      coreByteEn == hbc_lane_be(st_r.index[IDX_LANE_BIT]))
    else $error("byte access on wrong lane");

  mem_sel_a: assert property (
    $rose(coreReq) && busDirect |-> coreMem == $past(p.mr))
    else $error("memory select not taken from pin");

  full_read_a: assert property (
    $rose(coreReq) && busDirect && bus16 && laneWr &&
      !coreWrite |-> coreByteEn == BE_BOTH)
    else $error("per-lane family read not full word");

  direct_read_c: cover property (
    $rose(coreReq) && busDirect && !coreWrite ##[1:20] hostWaitN);
  byte_write_c: cover property (
    $rose(coreReq) && !busDirect && coreWrite &&
      coreByteEn == BE_HIGH);
  serial_sel_c: cover property (serialSel && serialTwoWire);

endmodule

/* File: dv/hbc_core_model.sv */
// hbc_core_model: core-side responder behind the host port.
// assumes: same clock as the port; a request is held until acked.
`timescale 1ns/1ps
module hbc_core_model
  import hbc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [3:0]        lat,
  input  wire logic              coreReq,
  input  wire logic [20:0]       coreAddr,
  output logic [DATA_W-1:0]      coreRdata,
  output logic                   coreAck
);
  logic [3:0]  cnt;
  logic        done;
  logic [15:0] junk;
  // idle read data churns so a stale sample never looks right
  assign coreRdata = coreAck ? (coreAddr[15:0] ^ 16'ha5c3) : junk;
  // one ack pulse per request, lat cycles late, so slow cores are covered
  always @(posedge clock) begin
    junk <= junk + 16'h3b1d;
    coreAck <= 1'b0;
    if (!nrst || !coreReq) begin
      cnt <= 4'h0;
      done <= 1'b0;
    end else if (!done) begin
      if (cnt == lat) begin
        coreAck <= 1'b1;
        done <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
  initial junk = 16'h1234;
endmodule

/* File: dv/hbc_tb.sv */
// testbench: straps, lane mapping and host/register port of the block.
// assumes: core side answered by the responder model.
`timescale 1ns/1ps
module testbench;
  import hbc_pkg::*;
  logic clock = 0, nrst = 0, clkEn = 1, fg = 0, wf = 0, csN = 1, rdN = 1;
  logic rwN = 1, loN = 1, hiN = 1, mem = 0, eaN = 1, bipN = 1, brN = 1;
  logic [20:0] addr = 0, cAddr;
  logic [15:0] din = 0, dout, cWd, cRd, rWd = 0, rRd;
  logic oeL, oeH, waitN, cReq, cWr, cMem, cAck, regWr = 0, regRd = 0;
  logic [1:0] cBe, fam, regA = 0;
  logic b16, bDir, ser, two, cam, gpio;
  logic [2:0] bType;
  logic [3:0] lat = 0;
  int miscompares = 0, n_compared = 0, cyc = 0;
  logic [15:0] gd, gWd;
  logic [1:0] gBe;
  logic [20:0] gA;
  logic gW, gM, gReq;

  always #25 clock = ~clock;
  hbc_lane_map u_dut (.clock(clock), .nrst(nrst), .clkEn(clkEn),
    .strapFamilyGroup(fg), .strapWidthOrFamily(wf), .hostCsN(csN),
    .hostRdN(rdN), .hostRdWrN(rwN), .lowLaneEnableN(loN),
    .highLaneEnableN(hiN), .memRegSel(mem), .busErrorAckN(eaN),
    .burstInProgressN(bipN), .burstReqN(brN), .hostAddr(addr),
    .hostDataIn(din), .hostDataOut(dout), .hostDataOeLow(oeL),
    .hostDataOeHigh(oeH), .hostWaitN(waitN), .coreReq(cReq),
    .coreWrite(cWr), .coreMem(cMem), .coreAddr(cAddr), .coreWdata(cWd),
    .coreByteEn(cBe), .coreRdata(cRd), .coreAck(cAck), .busFamily(fam),
    .bus16(b16), .busDirect(bDir), .busType(bType), .serialSel(ser),
    .serialTwoWire(two), .cameraStream(cam), .gpioHandover(gpio),
    .regAddr(regA), .regWdata(rWd), .regWr(regWr), .regRd(regRd),
    .regRdata(rRd));
  hbc_core_model u_core (.clock(clock), .nrst(nrst), .lat(lat),
    .coreReq(cReq), .coreAddr(cAddr), .coreRdata(cRd), .coreAck(cAck));

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, sized well above the whole sequence
  always @(posedge clock) begin
    cyc++;
    if (cyc > 4000) begin
      miscompares++;
      final_report();
    end
  end
  // straps 1..7; strap six goes on every pin that may carry it
  task automatic strap(logic g, w, s3, s4, s5, s6, s7);
    @(posedge clock);
    nrst <= 0; fg <= g; wf <= w; eaN <= s3; bipN <= s4; brN <= s5;
    hiN <= s6; addr <= {16'h0, s7, s6, 2'b0, s6};
    repeat (4) @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    hiN <= 1; addr <= 0; bipN <= 1; brN <= 1; eaN <= 1; fg <= ~g;
    #1;
  endtask
  task automatic rg(logic wr, logic [1:0] a, logic [15:0] d);
    @(posedge clock);
    regWr <= wr; regRd <= ~wr; regA <= a; rWd <= d;
    @(posedge clock);
    regWr <= 0; regRd <= 0;
    #1 gd = rRd;
  endtask
  // holds host pins until the block frees wait, then releases them
  task automatic host(logic r, w, logic [1:0] ln, logic [20:0] a,
                      logic [15:0] d, logic m, logic core);
    @(posedge clock);
    csN <= 0; rdN <= r; rwN <= w; loN <= ln[0]; hiN <= ln[1];
    addr <= a; din <= d; mem <= m;
    gReq = 0;
    repeat (core ? 30 : 6) begin
      @(posedge clock); #1;
      if (cReq === 1'b1 && !gReq) begin
        gReq = 1; gW = cWr; gA = cAddr; gBe = cBe; gM = cMem;
        gWd = cWd;
        chk("waitN held", waitN, 0);
      end
      if (gReq && waitN === 1'b1) break;
    end
    chk("core request", gReq, core);
    gd = dout;
    chk("oe high follows", oeH, oeL & r === 1'b0 & b16);
    @(posedge clock);
    csN <= 1; rdN <= 1; rwN <= 1; loN <= 1; hiN <= 1;
    repeat (6) @(posedge clock);
  endtask

  task automatic t_decode();
    logic [1:0] sw;
    strap(1, 0, 1, 1, 1, 1, 0); chk("fam A", fam, FAM_A);
    chk("fam A direct", bDir, 1);
    // strap pins have already moved; the snapshot must not follow them
    repeat (3) @(posedge clock);
    #1 chk("frozen", fam, FAM_A);
    strap(1, 1, 1, 1, 1, 0, 0); chk("fam B", fam, FAM_B);
    chk("fam B indirect", bDir, 0);
    for (int i = 0; i < 4; i++) begin
      sw = i[1:0];
      strap(0, sw[1], sw[0], 0, 1, 1, i[0]);
      chk("width", b16, sw[1]);
      chk("serial", ser, 1);
      chk("two wire", two, i[0]);
      chk("camera", cam, sw == CAM_WIDTH_DIR && !i[0]);
    end
    strap(0, 0, 1, 1, 0, 1, 0);
    chk("eight direct", bType, 3'h5);
    strap(0, 1, 1, 1, 1, 0, 0);
    chk("direct", bDir, 1);
    chk("type", bType, 3'h6);
    chk("gpio direct", gpio, 1);
    $display("test decode done");
  endtask
  task automatic t_direct();
    strap(0, 1, 1, 0, 0, 0, 0);
    chk("no gpio", gpio, 0);
    lat = 4'h3;
    host(0, 1, 2'b10, 21'h12344, 0, 1, 1);
    chk("read lanes", gBe, BE_LOW);
    chk("mem sel", gM, 1);
    chk("read data", gd, 16'h2344 ^ 16'ha5c3);
    host(1, 0, 2'b00, 21'h00046, 16'hbeef, 0, 1);
    chk("write", gW, 1);
    chk("write data", gWd, 16'hbeef);
    chk("reg sel", gM, 0);
    strap(0, 1, 1, 0, 0, 1, 0);
    lat = 4'h0;
    host(1, 1, 2'b01, 21'h00010, 16'h1234, 1, 1);
    chk("strobe lane", gBe, BE_HIGH);
    host(0, 1, 2'b11, 21'h00010, 0, 1, 1);
    chk("full read", gBe, BE_BOTH);
    rg(1, REG_CFG, 16'h0000);
    host(0, 1, 2'b00, 21'h00010, 0, 1, 0);
    rg(1, REG_CFG, 16'h0001);
    $display("test direct done");
  endtask
  task automatic t_indirect();
    strap(0, 1, 0, 0, 0, 0, 0);
    chk("indirect", bDir, 0);
    chk("gpio indirect", gpio, 1);
    // lane pins held low: shared-strobe host, index bit 15 picks byte or word accesses
    host(1, 0, 2'b00, {18'h0, PORT_INDEX, 1'b0}, 16'h8001, 0, 0);
    rg(0, REG_INDEX, 0); chk("index", gd, 16'h8001);
    host(0, 1, 2'b00, {18'h0, PORT_DATA, 1'b0}, 0, 0, 1);
    chk("byte hi", gBe, BE_HIGH);
    chk("hi byte", gd[15:8], 8'h00 ^ 8'ha5);
    chk("index addr", gA, 21'h1);
    host(1, 0, 2'b00, {18'h0, PORT_INDEX, 1'b0}, 16'h8000, 0, 0);
    host(1, 0, 2'b00, {18'h0, PORT_DATA, 1'b0}, 16'h00aa, 0, 1);
    chk("byte lo", gBe, BE_LOW);
    chk("byte data", gWd, 16'h00aa);
    host(1, 0, 2'b00, {18'h0, PORT_INDEX, 1'b0}, 16'h0002, 0, 0);
    host(1, 0, 2'b00, {18'h0, PORT_DATA, 1'b0}, 16'h5555, 0, 1);
    chk("word", gBe, BE_BOTH);
    // narrow bus: the index arrives low byte first
    strap(0, 0, 0, 0, 0, 0, 0);
    host(1, 0, 2'b11, 21'h0, 16'h0034, 0, 0);
    host(1, 0, 2'b11, 21'h0, 16'h0012, 0, 0);
    rg(0, REG_INDEX, 0); chk("index pair", gd, 16'h1234);
    host(0, 1, 2'b11, {19'h0, PORT_DATA}, 0, 0, 1);
    chk("narrow lane", gBe, BE_LOW);
    chk("narrow read", gd, {8'h00, 8'h34 ^ 8'hc3});
    // per-lane strobe host: both lane pins carry one write strobe
    strap(0, 1, 0, 0, 0, 1, 0);
    chk("strap six", bType, 3'h1);
    host(1, 1, 2'b00, 21'h0, 16'h0003, 0, 0);
    rg(0, REG_INDEX, 0); chk("strobe write", gd, 16'h0003);
    $display("test indirect done");
  endtask
  task automatic t_regs();
    rg(0, REG_CFG, 0); chk("cfg reset", gd, CFG_RST);
    // a write while the enable is low must leave no trace
    @(posedge clock);
    clkEn <= 0; regWr <= 1; regA <= REG_CFG; rWd <= 16'h0000;
    @(posedge clock);
    clkEn <= 1; regWr <= 0;
    rg(0, REG_CFG, 0); chk("frozen cfg", gd, CFG_RST);
    rg(1, REG_STATUS, 16'hffff);
    rg(0, REG_STATUS, 0); chk("status ro", gd, 16'h046c);
    rg(0, 2'h3, 0); chk("unmapped", gd, 0);
    @(posedge clock); #1 chk("read gone", rRd, 0);
    $display("test regs done");
  endtask

  initial begin
    @(posedge clock);
    @(posedge clock);
    nrst <= 1;
    // straps first: the opening reset is too short to fill the snapshot
    t_decode();
    t_regs();
    t_direct();
    t_indirect();
    final_report();
  end
endmodule
